/* File: mirg_checker.sv */
// checker for the command port between host and module
`timescale 1ns/1ps
module mirg_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic [1:0] status,
    input wire logic irq_req_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    chk_data_gate: assert property (cmd_rdata[7] && status[1] |-> !irq_req_n)
        else $error("data available gate");
    chk_free_gate: assert property (cmd_rdata[6] && status[0] |-> !irq_req_n)
        else $error("buffer free gate");
    chk_irq_release: assert property (!(cmd_rdata[7] && status[1])
        && !(cmd_rdata[6] && status[0]) |-> irq_req_n) else $error("irq held");
    chk_rsv_zero: assert property (cmd_wr |=> cmd_rdata[5:4] == 2'h0)
        else $error("reserved bits");
    chk_en_take: assert property (cmd_wr |=> cmd_rdata[7:6] == $past(cmd_wdata[7:6]))
        else $error("enable write");
    chk_cmd_keep: assert property (cmd_wr |=> cmd_rdata[3:0] == $past(cmd_wdata[3:0]))
        else $error("command bits");
    chk_rst_start: assert property (cmd_wr && cmd_wdata[3] |=> status == 2'h0)
        else $error("reset start");
    chk_rst_done: assert property (cmd_wr && cmd_wdata[3] |=> ##[1:9] status[0])
        else $error("reset done");
    cover property (cmd_wr && cmd_wdata[3]);
    cover property (!irq_req_n && status[1]);
    cover property ($fell(status[0]) && !cmd_rdata[3]);
endmodule // mirg_checker

/* File: mirg_device.sv */
// module side: command register, status flags and interrupt request gating
`timescale 1ns/1ps
// Function
// RULE1: data-available enable at bit 7 gates request
// RULE2: buffer-free enable at bit 6 gates request
// RULE3: bits 5 and 4 reserved, no function
// RULE4: bits 3..0 keep command meanings
// RULE5: request is OR of gated flags
// RULE6: polling host writes both enables zero
// RULE7: host reads both flags on interrupt
// RULE8: host accepts buffer-free already cleared
// RULE9: module may claim buffer, clearing buffer-free
// RULE10: multi-socket host separates only card enable
// RULE11: host bypasses empty socket stream tristate
// RULE12: enables present from first version
// RULE13: reset completion sets buffer-free flag
// RULE14: other commands take effect immediately
// RULE15: request releases when no gated term
module mirg_device (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    mirg_if.device bus,
    input wire logic i_data_ready,
    input wire logic i_buf_claim,
    input wire logic i_buf_release,
    output logic o_iface_reset_cmd,
    output logic o_size_read_cmd,
    output logic o_size_write_cmd,
    output logic o_host_control_cmd
);
    import mirg_pkg::*;

    // command register group
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [7:0] cmd_wdata_kept;

    // status flag group
    logic data_avail_flag_q;
    logic data_avail_flag_d;
    logic buf_free_flag_q;
    logic buf_free_flag_d;
    logic flag_hold;
    logic data_set;
    logic free_clear;
    logic free_set;
    logic [1:0] status_w;

    // interface reset sequencer group
    mirg_dev_state_e st_q;
    mirg_dev_state_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic reset_start;
    logic reset_busy;
    logic reset_done;

    // request line group
    logic irq_q;
    logic irq_d;
    logic data_avail_gated;
    logic buf_free_gated;

    // sequencer decode: start only from idle, done on last count
    always_comb begin
        reset_start = 1'b0;
        reset_busy = 1'b0;
        reset_done = 1'b0;
        unique case (st_q)
            MIRG_DEV_IDLE: begin
                reset_start = bus.cmd_wr & bus.cmd_wdata[MIRG_CMD_IFACE_RESET_BIT];
            end
            MIRG_DEV_RESETTING: begin
                reset_busy = 1'b1;
                reset_done = (cnt_q == 4'h1);
            end
            default: begin
                reset_busy = 1'b0;
            end
        endcase
    end

    // sequencer next state and completion count
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (reset_start) begin
            st_d = MIRG_DEV_RESETTING;
            cnt_d = MIRG_RESET_CYCLES;
        end else if (reset_done) begin
            st_d = MIRG_DEV_IDLE;
            cnt_d = 4'h0;
        end else if (reset_busy) begin
            cnt_d = cnt_q - 4'h1;
        end else begin
            st_d = MIRG_DEV_IDLE;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= MIRG_DEV_IDLE;
            cnt_q <= 4'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // reserved bits never reach the register
    always_comb begin
        cmd_wdata_kept = bus.cmd_wdata & MIRG_CMD_WR_MASK; // RULE12
        cmd_wdata_kept[MIRG_CMD_RSV5_BIT] = 1'b0; // RULE3
        cmd_wdata_kept[MIRG_CMD_RSV4_BIT] = 1'b0; // RULE3
    end

    // command register: reset bit self-clears at completion
    always_comb begin
        cmd_d = cmd_q;
        if (bus.cmd_wr) begin
            cmd_d = cmd_wdata_kept;
        end
        if (reset_done) begin
            cmd_d[MIRG_CMD_IFACE_RESET_BIT] = 1'b0; // RULE13
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cmd_q <= MIRG_CMD_RESET;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // flag events ignored while an interface reset runs
    always_comb begin
        flag_hold = reset_start | reset_busy;
        data_set = i_data_ready & ~flag_hold;
        free_clear = i_buf_claim & ~flag_hold;
        free_set = i_buf_release & ~flag_hold;
    end

    // status flags: release wins over claim in one cycle
    // reset clears both, completion sets buffer-free
    always_comb begin
        data_avail_flag_d = data_avail_flag_q;
        buf_free_flag_d = buf_free_flag_q;
        if (data_set) begin
            data_avail_flag_d = 1'b1;
        end
        if (free_clear) begin
            buf_free_flag_d = 1'b0; // RULE9
        end
        if (free_set) begin
            buf_free_flag_d = 1'b1;
        end
        if (flag_hold) begin
            data_avail_flag_d = 1'b0;
            buf_free_flag_d = 1'b0;
        end
        if (reset_done) begin
            buf_free_flag_d = 1'b1; // RULE13
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            data_avail_flag_q <= 1'b0;
            buf_free_flag_q <= 1'b1;
        end else begin
            data_avail_flag_q <= data_avail_flag_d;
            buf_free_flag_q <= buf_free_flag_d;
        end
    end

    // status word by field position
    always_comb begin
        status_w = 2'h0;
        status_w[MIRG_STS_DATA_AVAIL_BIT] = data_avail_flag_q;
        status_w[MIRG_STS_BUF_FREE_BIT] = buf_free_flag_q;
    end

    // request line follows next-state terms so it moves with flag and enable
    always_comb begin
        data_avail_gated = cmd_d[MIRG_CMD_DATA_IRQ_EN_BIT] & data_avail_flag_d; // RULE1
        buf_free_gated = cmd_d[MIRG_CMD_FREE_IRQ_EN_BIT] & buf_free_flag_d; // RULE2
        irq_d = data_avail_gated | buf_free_gated; // RULE5 RULE15
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // port side views of the registers
    assign bus.cmd_rdata = cmd_q;
    assign bus.status = status_w;
    assign bus.irq_req_n = ~irq_q;

    // RULE4 RULE14
    assign o_iface_reset_cmd = cmd_q[MIRG_CMD_IFACE_RESET_BIT];
    assign o_size_read_cmd = cmd_q[MIRG_CMD_SIZE_READ_BIT];
    assign o_size_write_cmd = cmd_q[MIRG_CMD_SIZE_WRITE_BIT];
    assign o_host_control_cmd = cmd_q[MIRG_CMD_HOST_CTRL_BIT];
endmodule // mirg_device

/* File: mirg_host.sv */
// host side: controller registers driving the module command port
`timescale 1ns/1ps
module mirg_host (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    mirg_if.host bus,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq
);
    import mirg_pkg::*;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] ists_q, ists_d, ien_q, ien_d;
    logic free_seen_q, free_seen_d;
    logic line, free_lost;

    assign line = ~bus.irq_req_n;
    // flag gone before service is normal, noted in MIRG_IRQ_FREE_LOST_BIT, which raises o_irq when enabled
    // a fall caused by the host's own interface reset is not counted
    assign free_lost = free_seen_q & ~bus.status[MIRG_STS_BUF_FREE_BIT]
        & ~bus.cmd_rdata[MIRG_CMD_IFACE_RESET_BIT]; // RULE8
    assign bus.cmd_wr = i_wr && (i_addr == MIRG_REG_CMD); // RULE6
    assign bus.cmd_wdata = i_wdata;

    always_comb begin
        rdata_d = 8'h00;
        ists_d = ists_q;
        ien_d = ien_q;
        free_seen_d = bus.status[MIRG_STS_BUF_FREE_BIT];
        if (i_wr && i_addr == MIRG_REG_IRQ_CLR) begin
            ists_d = ists_q & ~i_wdata[1:0];
        end
        if (i_wr && i_addr == MIRG_REG_IRQ_EN) begin
            ien_d = i_wdata[1:0];
        end
        if (line) begin
            ists_d[MIRG_IRQ_LINE_BIT] = 1'b1;
        end
        if (free_lost) begin
            ists_d[MIRG_IRQ_FREE_LOST_BIT] = 1'b1;
        end
        if (i_rd) begin
            unique case (i_addr)
                MIRG_REG_CMD: rdata_d = bus.cmd_rdata;
                MIRG_REG_STATUS: rdata_d = {6'h00, bus.status}; // RULE7
                MIRG_REG_IRQ_STS: rdata_d = {6'h00, ists_q};
                MIRG_REG_IRQ_EN: rdata_d = {6'h00, ien_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
            ists_q <= MIRG_IRQ_RESET;
            ien_q <= MIRG_IRQ_RESET;
            free_seen_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ists_q <= ists_d;
            ien_q <= ien_d;
            free_seen_q <= free_seen_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = |(ists_q & ien_q);
endmodule // mirg_host

/* File: mirg_if.sv */
// interface joining host controller and module command port
`timescale 1ns/1ps
interface mirg_if;
    logic cmd_wr;
    logic [7:0] cmd_wdata;
    logic [7:0] cmd_rdata;
    logic [1:0] status;
    logic irq_req_n;
    modport device (input cmd_wr, input cmd_wdata, output cmd_rdata, output status,
        output irq_req_n);
    modport host (output cmd_wr, output cmd_wdata, input cmd_rdata, input status,
        input irq_req_n);
endinterface

/* File: mirg_pkg.sv */
// package with command register layout, status layout and controller register map
package mirg_pkg;
    localparam int MIRG_CMD_W = 8;
    localparam int MIRG_CMD_DATA_IRQ_EN_BIT = 7;
    localparam int MIRG_CMD_FREE_IRQ_EN_BIT = 6;
    localparam int MIRG_CMD_RSV5_BIT = 5;
    localparam int MIRG_CMD_RSV4_BIT = 4;
    localparam int MIRG_CMD_IFACE_RESET_BIT = 3;
    localparam int MIRG_CMD_SIZE_READ_BIT = 2;
    localparam int MIRG_CMD_SIZE_WRITE_BIT = 1;
    localparam int MIRG_CMD_HOST_CTRL_BIT = 0;
    localparam logic [7:0] MIRG_CMD_RESET = 8'h00;
    localparam logic [7:0] MIRG_CMD_WR_MASK = 8'hcf;
    localparam int MIRG_STS_DATA_AVAIL_BIT = 1;
    localparam int MIRG_STS_BUF_FREE_BIT = 0;
    // interface reset completion delay, in cycles
    localparam logic [3:0] MIRG_RESET_CYCLES = 4'h8;
    // host controller register map
    localparam logic [3:0] MIRG_REG_CMD = 4'h0;
    localparam logic [3:0] MIRG_REG_STATUS = 4'h1;
    localparam logic [3:0] MIRG_REG_IRQ_STS = 4'h2;
    localparam logic [3:0] MIRG_REG_IRQ_CLR = 4'h3;
    localparam logic [3:0] MIRG_REG_IRQ_EN = 4'h4;
    localparam int MIRG_IRQ_LINE_BIT = 0;
    localparam int MIRG_IRQ_FREE_LOST_BIT = 1;
    localparam logic [1:0] MIRG_IRQ_RESET = 2'h0;
    typedef enum logic [1:0] {
        MIRG_DEV_IDLE = 2'b00,
        MIRG_DEV_RESETTING = 2'b01
    } mirg_dev_state_e;
endpackage

/* File: mirg_tb.sv */
// self-checking bench joining host controller and module
`timescale 1ns/1ps
module mirg_tb;
    import mirg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] co;
    logic [15:0] lf = 16'hd617;
    logic [7:0] expq[$];
    int fail_count = 0;
    int samples_checked = 0;
    int k;
    mirg_if mif();
    mirg_device u_mirg_device(.i_ref_clk(clk), .i_rst(rst), .bus(mif), .i_data_ready(ev[0]),
        .i_buf_claim(ev[1]), .i_buf_release(ev[2]), .o_iface_reset_cmd(co[3]),
        .o_size_read_cmd(co[2]), .o_size_write_cmd(co[1]), .o_host_control_cmd(co[0]));
    mirg_host u_mirg_host(.i_ref_clk(clk), .i_rst(rst), .bus(mif), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
    mirg_checker u_mirg_checker(.i_ref_clk(clk), .i_rst(rst), .cmd_wr(mif.cmd_wr),
        .cmd_wdata(mif.cmd_wdata), .cmd_rdata(mif.cmd_rdata), .status(mif.status),
        .irq_req_n(mif.irq_req_n));
    always #20 clk = ~clk;
    task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask
    task pulse(input logic [2:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 3'h0;
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d fails %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) cmp("rdata", expq.pop_front(), rdata);
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(MIRG_REG_STATUS, 8'h01);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr_next(lf);
            wr_reg(MIRG_REG_CMD, lf[7:0] & 8'hf7);
            rd_reg(MIRG_REG_CMD, lf[7:0] & 8'hc7);
            cmp("cmd", {5'h0, lf[2:0]}, {4'h0, co});
            cmp("irqn", {7'h0, !lf[6]}, {7'h0, mif.irq_req_n});
        end
        $display("test cmd done");
        wr_reg(MIRG_REG_CMD, 8'hc0);
        pulse(3'h2);
        cmp("sts", 8'h00, {6'h0, mif.status});
        cmp("irqn", 8'h01, {7'h0, mif.irq_req_n});
        pulse(3'h1);
        cmp("sts", 8'h02, {6'h0, mif.status});
        cmp("irqn", 8'h00, {7'h0, mif.irq_req_n});
        pulse(3'h6);
        cmp("sts", 8'h03, {6'h0, mif.status});
        cmp("irqn", 8'h00, {7'h0, mif.irq_req_n});
        wr_reg(MIRG_REG_CMD, 8'h00);
        cmp("irqn", 8'h01, {7'h0, mif.irq_req_n});
        $display("test gate done");
        wr_reg(MIRG_REG_CMD, 8'h48);
        cmp("sts", 8'h00, {6'h0, mif.status});
        cmp("cmd", 8'h08, {4'h0, co});
        for (k = 0; k < 12 && !mif.status[0]; k++) begin
            @(posedge clk);
            #1;
        end
        cmp("rst_len", {4'h0, MIRG_RESET_CYCLES}, k[7:0]);
        cmp("irqn", 8'h00, {7'h0, mif.irq_req_n});
        cmp("cmd", 8'h00, {4'h0, co});
        $display("test reset done");
        wr_reg(MIRG_REG_IRQ_EN, 8'h01);
        wr_reg(MIRG_REG_IRQ_CLR, 8'h03);
        @(posedge clk);
        #1;
        cmp("irq", 8'h01, {7'h0, irq});
        rd_reg(MIRG_REG_IRQ_STS, 8'h01);
        pulse(3'h2);
        rd_reg(MIRG_REG_IRQ_STS, 8'h03);
        wr_reg(MIRG_REG_CMD, 8'h00);
        wr_reg(MIRG_REG_IRQ_CLR, 8'h01);
        cmp("irq", 8'h00, {7'h0, irq});
        rd_reg(MIRG_REG_IRQ_EN, 8'h01);
        wr_reg(MIRG_REG_IRQ_EN, 8'h02);
        cmp("irq", 8'h01, {7'h0, irq});
        rd_reg(MIRG_REG_IRQ_EN, 8'h02);
        rd_reg(MIRG_REG_IRQ_CLR, 8'h00);
        rd_reg(4'hf, 8'h00);
        repeat (2) @(negedge clk);
        cmp("queue", 8'h00, 8'(expq.size()));
        $display("test irq done");
        report_and_stop;
    end
endmodule // mirg_tb
